/* File: common/mov_or_pkg.sv */
// Shared constants and types for the move and logical-OR executor
package mov_or_pkg;
   // Opcodes, full byte or masked
   localparam logic [7:0] OP_NOP = 8'h00;
   localparam logic [7:0] OP_JUMP_ZERO = 8'hc6;
   localparam logic [7:0] OP_MOV_A_IMM = 8'h23;
   localparam logic [7:0] OP_MOV_A_STAT = 8'hc7;
   localparam logic [7:0] OP_MOV_STAT_A = 8'hd7;
   localparam logic [7:0] OP_MOV_A_T = 8'h42;
   localparam logic [7:0] OP_MOV_T_A = 8'h62;
   localparam logic [7:0] OP_PAGE_LOOKUP = 8'ha3;
   localparam logic [7:0] OP_PAGE3_LOOKUP = 8'he3;
   localparam logic [7:0] OP_OR_A_IMM = 8'h43;
   localparam logic [7:0] OP_OR_BUS = 8'h88;
   localparam logic [4:0] OP_MOV_A_R = 5'h1f;
   localparam logic [4:0] OP_MOV_R_A = 5'h15;
   localparam logic [4:0] OP_MOV_R_IMM = 5'h17;
   localparam logic [4:0] OP_OR_A_R = 5'h09;
   localparam logic [6:0] OP_MOV_A_IND = 7'h78;
   localparam logic [6:0] OP_MOV_IND_A = 7'h50;
   localparam logic [6:0] OP_MOV_IND_IMM = 7'h58;
   localparam logic [6:0] OP_XRAM_RD = 7'h40;
   localparam logic [6:0] OP_XRAM_WR = 7'h48;
   localparam logic [6:0] OP_OR_A_IND = 7'h20;
   localparam logic [5:0] OP_EXP_RD = 6'h03;
   localparam logic [5:0] OP_EXP_WR = 6'h0f;
   // Status word layout
   localparam int STAT_CY = 7;
   localparam int STAT_AC = 6;
   localparam int STAT_UF0 = 5;
   localparam int STAT_BS = 4;
   localparam int STAT_ONE = 3;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [3:0] STAT_HI_RST = 4'h0;
   localparam logic [2:0] PAGE_THREE = 3'b011;
   localparam int RAM_AW = 8;

   // Internal RAM access bundle
   typedef struct packed {
      logic we;
      logic [RAM_AW-1:0] addr;
      logic [7:0] wdata;
   } ram_req_t;

   // External data RAM request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } xram_req_t;
endpackage : mov_or_pkg

/* File: core/iram.sv */
// Internal data RAM with registered read data
`timescale 1ns/1ps
module iram #(
   parameter int AW = 8
) (
   input wire logic sys_clk, // Core clock
   input wire logic ce, // Clock enable
   input wire logic we, // Write strobe
   input wire logic [AW-1:0] waddr, // Write address
   input wire logic [7:0] wdata, // Write data
   input wire logic [AW-1:0] raddr, // Read address
   output logic [7:0] rdata // Registered read data
);
   logic [7:0] mem [0:(1<<AW)-1];

   // Write and registered read of the old data, both gated by enable
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end
endmodule : iram

/* File: core/mov_or_exec.sv */
// Executor for moves, table lookups, external RAM moves and logical ORs
// Operation
// - Jump-if-zero loads PC low byte when A zero
// - Immediate move loads A from byte two
// - Status read copies full word into A
// - Status word: flags, bank, one, stack bits
// - Status write replaces flag and bank bits from A high nibble
// - Register read selects by low opcode bits
// - Indirect uses R0/R1, 6/7/8 address bits
// - Timer read copies timer into A
// - A written into selected working register
// - Immediate byte written into working register
// - A stored indirectly, pointer unchanged
// - Immediate byte stored indirectly
// - Timer write loads timer from A
// - Expander read: nibble in, high cleared
// - Expander write sends low nibble out
// - Page lookup uses A as PC low
// - Page three lookup uses 011 high bits
// - External read via pointer loads A
// - External write stores A via pointer
// - No-op changes nothing, one cycle
// - OR into A from register, RAM, immediate
// - Bus OR combines immediate with bus latch
// - Bus OR result driven to bus port
`timescale 1ns/1ps
module mov_or_exec #(
   parameter int RAM_BITS = 6, // 6, 7 or 8 address bits
   parameter int PC_W = 12
) (
   input wire logic sys_clk, // Instruction-cycle clock
   input wire logic nrst, // Async reset, low
   input wire logic ce, // Clock enable
   input wire logic [7:0] op, // Current opcode byte
   input wire logic op_valid, // Opcode presented for execution
   input wire logic [7:0] byte2, // Second instruction byte
   input wire logic [7:0] rom_data, // Program memory byte
   input wire logic [2:0] stack_level, // Live stack pointer
   input wire logic [7:0] timer_val, // Timer/counter value
   input wire logic [3:0] exp_in, // Expander port input nibble
   input wire logic [7:0] xram_rdata, // External RAM read data
   input wire logic [PC_W-1:0] pc_in, // Current program counter
   output logic busy, // Second cycle of a two-cycle op
   output logic done, // Instruction finishes this cycle
   output logic [7:0] acc_ff, // Accumulator
   output logic [7:0] program_status_word, // Status word view
   output logic pc_load, // Load PC low byte
   output logic [7:0] pc_low, // New PC low byte
   output logic [PC_W-1:0] rom_addr_ff, // Lookup fetch address
   output logic rom_rd_ff, // Lookup fetch strobe
   output logic timer_we_ff, // Timer load strobe
   output logic [7:0] timer_wdata_ff, // Timer load value
   output logic exp_we_ff, // Expander write strobe
   output logic exp_rd_ff, // Expander read strobe
   output logic [1:0] selected_port_ff, // Expander port 4..7
   output logic [3:0] exp_out_ff, // Expander write nibble
   output mov_or_pkg::xram_req_t xram_ff, // External RAM request
   output logic [7:0] bus_out_ff, // Bus port latch
   output logic bus_oe_ff // Bus port drive enable
);
   typedef enum logic [1:0] {
      ST_FIRST = 2'b01,
      ST_SECOND = 2'b10
   } st_t;

   st_t st_ff;
   st_t nxt_st;
   logic [7:0] op_ff;
   logic [7:0] regs_ff [0:7];
   logic [3:0] stat_hi_ff;
   logic [7:0] ram_rdata;
   mov_or_pkg::ram_req_t ram_req;

   // Masked opcode compare
   function automatic logic hit(input logic [7:0] o, input logic [7:0] pat,
                                input int lsb);
      hit = (o >> lsb) == (pat >> lsb);
   endfunction : hit

   // Indirect address from R0/R1, trimmed to RAM size
   function automatic logic [7:0] ind_addr(input logic [7:0] ptr);
      ind_addr = ptr & 8'((1 << RAM_BITS) - 1);
   endfunction : ind_addr

   // Decode on the live opcode, or the latched one in the second cycle
   wire [7:0] cur = (st_ff == ST_SECOND) ? op_ff : op;
   wire [2:0] rsel = cur[2:0];
   wire [7:0] rval = regs_ff[rsel];
   wire [7:0] ptr = regs_ff[{2'b00, cur[0]}];
   wire d_jmpz = cur == mov_or_pkg::OP_JUMP_ZERO;
   wire d_mai = cur == mov_or_pkg::OP_MOV_A_IMM;
   wire d_map = cur == mov_or_pkg::OP_MOV_A_STAT;
   wire d_mpa = cur == mov_or_pkg::OP_MOV_STAT_A;
   wire d_mat = cur == mov_or_pkg::OP_MOV_A_T;
   wire d_mta = cur == mov_or_pkg::OP_MOV_T_A;
   wire d_mvp = cur == mov_or_pkg::OP_PAGE_LOOKUP;
   wire d_mp3 = cur == mov_or_pkg::OP_PAGE3_LOOKUP;
   wire d_oai = cur == mov_or_pkg::OP_OR_A_IMM;
   wire d_obs = cur == mov_or_pkg::OP_OR_BUS;
   wire d_mar = hit(cur, {mov_or_pkg::OP_MOV_A_R, 3'b000}, 3);
   wire d_mra = hit(cur, {mov_or_pkg::OP_MOV_R_A, 3'b000}, 3);
   wire d_mri = hit(cur, {mov_or_pkg::OP_MOV_R_IMM, 3'b000}, 3);
   wire d_oar = hit(cur, {mov_or_pkg::OP_OR_A_R, 3'b000}, 3);
   wire d_maind = hit(cur, {mov_or_pkg::OP_MOV_A_IND, 1'b0}, 1);
   wire d_mia = hit(cur, {mov_or_pkg::OP_MOV_IND_A, 1'b0}, 1);
   wire d_mii = hit(cur, {mov_or_pkg::OP_MOV_IND_IMM, 1'b0}, 1);
   wire d_xrd = hit(cur, {mov_or_pkg::OP_XRAM_RD, 1'b0}, 1);
   wire d_xwr = hit(cur, {mov_or_pkg::OP_XRAM_WR, 1'b0}, 1);
   wire d_oaind = hit(cur, {mov_or_pkg::OP_OR_A_IND, 1'b0}, 1);
   wire d_drd = hit(cur, {mov_or_pkg::OP_EXP_RD, 2'b00}, 2);
   wire d_dwr = hit(cur, {mov_or_pkg::OP_EXP_WR, 2'b00}, 2);
   wire two_cyc = d_jmpz | d_mai | d_mri | d_mii | d_drd | d_dwr | d_mvp
      | d_mp3 | d_xrd | d_xwr | d_oai | d_obs;
   wire first = (st_ff == ST_FIRST) & op_valid;
   wire second = st_ff == ST_SECOND;
   wire stat_one = 1'b1;

   // Status word view: high flags, fixed one, live stack level
   assign program_status_word = {stat_hi_ff, stat_one, stack_level};

   // Sequencing of one- and two-cycle instructions
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_FIRST: begin
            if (op_valid && two_cyc) begin
               nxt_st = ST_SECOND;
            end
         end
         ST_SECOND: begin
            nxt_st = ST_FIRST;
         end
         default: begin
            nxt_st = ST_FIRST;
         end
      endcase
   end

   assign busy = second;
   assign done = (first & ~two_cyc) | second;
   // Jump if zero, taken in the second cycle
   assign pc_load = second & d_jmpz & (acc_ff == 8'h00);
   assign pc_low = byte2;

   // Internal RAM port: indirect stores and reads via R0/R1
   assign ram_req.we = (first & d_mia) | (second & d_mii);
   assign ram_req.addr = ind_addr(ptr);
   assign ram_req.wdata = d_mii ? byte2 : acc_ff;

   iram #(
      .AW(mov_or_pkg::RAM_AW)
   ) i_iram (
      .sys_clk(sys_clk),
      .ce(ce),
      .we(ram_req.we),
      .waddr(ram_req.addr),
      .wdata(ram_req.wdata),
      .raddr(ind_addr(regs_ff[{2'b00, op[0]}])),
      .rdata(ram_rdata)
   );

   // Indirect RAM reads are served from the registered read port a cycle
   // after the opcode is presented; the indirect forms use that cycle.
   logic ind_pend_ff;

   // Sequencer state and latched opcode
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= ST_FIRST;
         op_ff <= mov_or_pkg::OP_NOP;
      end else if (ce) begin
         st_ff <= nxt_st;
         if (first) begin
            op_ff <= op;
         end
      end
   end

   // Accumulator next value
   logic [7:0] nxt_acc;
   always_comb begin
      nxt_acc = acc_ff;
      if (first) begin
         if (d_map) nxt_acc = program_status_word;
         if (d_mar) nxt_acc = rval;
         if (d_mat) nxt_acc = timer_val;
         if (d_oar) nxt_acc = acc_ff | rval;
      end
      if (ind_pend_ff) begin
         if (hit(op_ff, {mov_or_pkg::OP_MOV_A_IND, 1'b0}, 1)) begin
            nxt_acc = ram_rdata;
         end else begin
            nxt_acc = acc_ff | ram_rdata;
         end
      end
      if (second) begin
         if (d_mai) nxt_acc = byte2;
         if (d_oai) nxt_acc = acc_ff | byte2;
         if (d_drd) nxt_acc = {4'h0, exp_in};
         if (d_mvp | d_mp3) nxt_acc = rom_data;
         if (d_xrd) nxt_acc = xram_rdata;
      end
   end

   // Accumulator, status flags and indirect-read pending flag
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         acc_ff <= mov_or_pkg::ACC_RST;
         stat_hi_ff <= mov_or_pkg::STAT_HI_RST;
         ind_pend_ff <= 1'b0;
      end else if (ce) begin
         acc_ff <= nxt_acc;
         ind_pend_ff <= first & (d_maind | d_oaind);
         if (first && d_mpa) begin
            stat_hi_ff <=
               acc_ff[mov_or_pkg::STAT_CY:mov_or_pkg::STAT_BS];
         end
      end
   end

   // Working registers R0..R7
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 8; i++) begin
            regs_ff[i] <= 8'h00;
         end
      end else if (ce) begin
         if (first && d_mra) begin
            regs_ff[rsel] <= acc_ff;
         end else if (second && d_mri) begin
            regs_ff[rsel] <= byte2;
         end
      end
   end

   // Timer load and program memory lookup address
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         timer_we_ff <= 1'b0;
         timer_wdata_ff <= 8'h00;
         rom_rd_ff <= 1'b0;
         rom_addr_ff <= '0;
      end else if (ce) begin
         timer_we_ff <= first & d_mta;
         if (first && d_mta) begin
            timer_wdata_ff <= acc_ff;
         end
         rom_rd_ff <= first & (d_mvp | d_mp3);
         if (first && d_mvp) begin
            rom_addr_ff <= {pc_in[PC_W-1:8], acc_ff};
         end else if (first && d_mp3) begin
            rom_addr_ff <= {pc_in[PC_W-1:11], mov_or_pkg::PAGE_THREE,
                            acc_ff};
         end
      end
   end

   // Expander port strobes, driven through the second cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         exp_we_ff <= 1'b0;
         exp_rd_ff <= 1'b0;
         selected_port_ff <= 2'b00;
         exp_out_ff <= 4'h0;
      end else if (ce) begin
         exp_we_ff <= first & d_dwr;
         exp_rd_ff <= first & d_drd;
         if (first && (d_dwr || d_drd)) begin
            selected_port_ff <= op[1:0];
            exp_out_ff <= acc_ff[3:0];
         end
      end
   end

   // External RAM request held during the second cycle
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         xram_ff <= '0;
      end else if (ce) begin
         xram_ff.rd <= first & d_xrd;
         xram_ff.wr <= first & d_xwr;
         if (first && (d_xrd || d_xwr)) begin
            xram_ff.addr <= ptr;
            xram_ff.wdata <= acc_ff;
         end
      end
   end

   // Bus port latch: OR with immediate, result driven back out
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bus_out_ff <= 8'h00;
         bus_oe_ff <= 1'b0;
      end else if (ce) begin
         if (second && d_obs) begin
            bus_out_ff <= bus_out_ff | byte2;
            bus_oe_ff <= 1'b1;
         end
      end
   end
endmodule : mov_or_exec

/* File: test/mov_or_exec_chk.sv */
// Assertion checker for the move and OR executor
`timescale 1ns/1ps
module mov_or_exec_chk #(
   parameter int PC_W = 12
) (
   input wire logic sys_clk, // Clock
   input wire logic nrst, // Reset
   input wire logic ce, // Enable
   input wire logic [7:0] op, // Opcode
   input wire logic op_valid, // Valid
   input wire logic [7:0] byte2, // Byte two
   input wire logic [2:0] stack_level, // Stack
   input wire logic [3:0] exp_in, // Nibble in
   input wire logic busy, // Busy
   input wire logic done, // Done
   input wire logic [7:0] acc_ff, // Acc
   input wire logic [7:0] program_status_word, // Status
   input wire logic pc_load, // Jump
   input wire logic [PC_W-1:0] rom_addr_ff, // Lookup address
   input wire logic rom_rd_ff, // Lookup strobe
   input wire logic timer_we_ff, // Timer strobe
   input wire logic [7:0] timer_wdata_ff, // Timer data
   input wire logic exp_rd_ff, // Port read
   input wire logic [1:0] selected_port_ff, // Port
   input wire mov_or_pkg::xram_req_t xram_ff, // Ext RAM
   input wire logic [7:0] bus_out_ff, // Bus latch
   input wire logic bus_oe_ff // Bus drive
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // Instruction accepted at this edge
   wire tk = ce && op_valid && !busy;
   // Instruction timing and results
   property p_jump_zero;
      tk && op == 8'hc6 |=> busy && pc_load == ($past(acc_ff) == 8'h00);
   endproperty
   a_jump_zero: assert property (p_jump_zero) else $error("jump wrong");
   property p_imm;
      tk && op == 8'h23 |=> busy ##1 acc_ff == $past(byte2);
   endproperty
   a_imm: assert property (p_imm) else $error("imm wrong");
   property p_stat_low;
      program_status_word[3:0] == {1'b1, stack_level};
   endproperty
   a_stat_low: assert property (p_stat_low) else $error("status low wrong");
   property p_stat_wr;
      tk && op == 8'hd7 |=>
         {program_status_word[7:4], 4'h0} == ($past(acc_ff) & 8'hf0);
   endproperty
   a_stat_wr: assert property (p_stat_wr) else $error("status wr wrong");
   property p_tmr;
      tk && op == 8'h62 |=> timer_we_ff && timer_wdata_ff == $past(acc_ff);
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer wrong");
   property p_exp_rd;
      tk && op[7:2] == 6'h03 |=> busy && exp_rd_ff
         && {6'h00, selected_port_ff} == ($past(op) & 8'h03)
         ##1 acc_ff == {4'h0, $past(exp_in)};
   endproperty
   a_exp_rd: assert property (p_exp_rd) else $error("port rd wrong");
   property p_xwr;
      tk && op[7:1] == 7'h48 |=> busy && xram_ff.wr
         && xram_ff.wdata == $past(acc_ff) ##1 acc_ff == $past(acc_ff, 2);
   endproperty
   a_xwr: assert property (p_xwr) else $error("ext wr wrong");
   property p_bus;
      tk && op == 8'h88 |=> busy ##1 bus_oe_ff
         && bus_out_ff == ($past(bus_out_ff, 2) | $past(byte2));
   endproperty
   a_bus: assert property (p_bus) else $error("bus or wrong");
   // No-op ends at once and leaves the accumulator alone
   property p_nop;
      tk && op == 8'h00 |-> done ##1 !busy && acc_ff == $past(acc_ff);
   endproperty
   a_nop: assert property (p_nop) else $error("nop wrong");
   // Page lookup fetches at the accumulator in its second cycle
   property p_lookup;
      tk && op == 8'ha3 |-> !done ##1 busy && done && rom_rd_ff
         && rom_addr_ff[7:0] == $past(acc_ff);
   endproperty
   a_lookup: assert property (p_lookup) else $error("lookup wrong");
endmodule : mov_or_exec_chk

bind mov_or_exec mov_or_exec_chk #(.PC_W(PC_W)) i_mov_or_exec_chk (
   .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .op(op), .op_valid(op_valid),
   .byte2(byte2), .stack_level(stack_level), .exp_in(exp_in), .busy(busy),
   .done(done), .acc_ff(acc_ff),
   .program_status_word(program_status_word),
   .pc_load(pc_load), .rom_addr_ff(rom_addr_ff), .rom_rd_ff(rom_rd_ff),
   .timer_we_ff(timer_we_ff),
   .timer_wdata_ff(timer_wdata_ff), .exp_rd_ff(exp_rd_ff),
   .selected_port_ff(selected_port_ff), .xram_ff(xram_ff),
   .bus_out_ff(bus_out_ff), .bus_oe_ff(bus_oe_ff));

/* File: test/xram_model.sv */
// External data RAM and expander port model
`timescale 1ns/1ps
module xram_model (
   input wire logic sys_clk, // Clock
   input wire mov_or_pkg::xram_req_t xram, // Request
   input wire logic exp_we, // Port write
   input wire logic exp_rd, // Port read
   input wire logic [1:0] port, // Port select
   input wire logic [3:0] exp_out, // Port data out
   output logic [7:0] rdata, // Read data
   output logic [3:0] exp_in // Port data in
);
   logic [7:0] mem [256];
   logic [3:0] pin [4];
   logic [7:0] cnt = 8'h00;
   // Store writes and run an idle pattern
   always @(posedge sys_clk) begin
      cnt <= cnt + 8'h01;
      if (xram.wr) mem[xram.addr] <= xram.wdata;
      if (exp_we) pin[port] <= exp_out;
   end
   // Idle lines change every cycle so stale data never looks valid
   assign rdata = xram.rd ? mem[xram.addr] : cnt;
   assign exp_in = exp_rd ? pin[port] : cnt[3:0];
endmodule : xram_model

/* File: test/tb_mov_or_exec.sv */
// Bench for the move and logical-OR executor
`timescale 1ns/1ps
module tb_mov_or_exec;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic op_valid = 1'b0;
   logic ce = 1'b1;
   logic saw = 1'b0;
   logic [7:0] op = 8'h00;
   logic [7:0] byte2 = 8'h00;
   logic [7:0] timer_val = 8'h00;
   logic [7:0] jaddr = 8'h00;
   logic [2:0] stack_level = 3'h5;
   logic [11:0] pc_in = 12'h5a7;
   logic busy, done, pc_load, rom_rd_ff, timer_we_ff, exp_we_ff, exp_rd_ff;
   logic bus_oe_ff;
   logic [7:0] acc_ff, program_status_word, pc_low, timer_wdata_ff;
   logic [7:0] xram_rdata, bus_out_ff, rom_data;
   logic [11:0] rom_addr_ff;
   logic [3:0] exp_in, exp_out_ff;
   logic [1:0] selected_port_ff;
   mov_or_pkg::xram_req_t xram_ff;
   int checked = 0;
   int err_total = 0;
   // Clock and program memory contents
   always #10 sys_clk = ~sys_clk;
   assign rom_data = rom_addr_ff[7:0] ^ 8'h55;
   // Record any jump request
   always @(posedge sys_clk) if (pc_load === 1'b1) begin
      saw <= 1'b1;
      jaddr <= pc_low;
   end
   mov_or_exec i_mov_or_exec (
      .sys_clk(sys_clk), .nrst(nrst), .ce(ce), .op(op),
      .op_valid(op_valid), .byte2(byte2), .rom_data(rom_data),
      .stack_level(stack_level), .timer_val(timer_val), .exp_in(exp_in),
      .xram_rdata(xram_rdata), .pc_in(pc_in), .busy(busy), .done(done),
      .acc_ff(acc_ff), .program_status_word(program_status_word),
      .pc_load(pc_load), .pc_low(pc_low), .rom_addr_ff(rom_addr_ff),
      .rom_rd_ff(rom_rd_ff), .timer_we_ff(timer_we_ff),
      .timer_wdata_ff(timer_wdata_ff), .exp_we_ff(exp_we_ff),
      .exp_rd_ff(exp_rd_ff), .selected_port_ff(selected_port_ff),
      .exp_out_ff(exp_out_ff), .xram_ff(xram_ff),
      .bus_out_ff(bus_out_ff), .bus_oe_ff(bus_oe_ff));
   xram_model i_xram_model (
      .sys_clk(sys_clk), .xram(xram_ff), .exp_we(exp_we_ff),
      .exp_rd(exp_rd_ff), .port(selected_port_ff), .exp_out(exp_out_ff),
      .rdata(xram_rdata), .exp_in(exp_in));
   // Issue one instruction and let it finish
   task automatic ex(input logic [7:0] o, input logic [7:0] b);
      @(posedge sys_clk) #1;
      op = o;
      op_valid = 1'b1;
      byte2 = b;
      @(posedge sys_clk) #1;
      op_valid = 1'b0;
      if (busy === 1'b1) @(posedge sys_clk) #1;
      @(posedge sys_clk) #1;
   endtask : ex
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : stop_test
   // Main sequence
   initial begin
      repeat (8) @(posedge sys_clk);
      #1 nrst = 1'b1;
      chk(program_status_word, 8'h0d);
      stack_level = 3'h2;
      #1 chk(program_status_word, 8'h0a);
      ex(8'h23, 8'ha5);
      chk(acc_ff, 8'ha5);
      ex(8'hd7, 8'h00);
      ex(8'h23, 8'h00);
      ex(8'hc7, 8'h00);
      chk(acc_ff, 8'haa);
      for (int r = 0; r < 8; r++) ex(8'hb8 | 8'(r), 8'h10 + 8'(r));
      for (int r = 0; r < 8; r++) begin
         ex(8'hf8 | 8'(r), 8'h00);
         chk(acc_ff, 8'h10 + 8'(r));
      end
      ex(8'h23, 8'h3c);
      ex(8'haf, 8'h00);
      ex(8'h23, 8'h01);
      ex(8'h4f, 8'h00);
      chk(acc_ff, 8'h3d);
      ex(8'hb8, 8'h45);
      ex(8'hb9, 8'h05);
      ex(8'hb0, 8'h77);
      ex(8'hf1, 8'h00);
      chk(acc_ff, 8'h77);
      ex(8'h23, 8'h81);
      ex(8'ha1, 8'h00);
      ex(8'hf9, 8'h00);
      chk(acc_ff, 8'h05);
      ex(8'h23, 8'h02);
      ex(8'h40, 8'h00);
      chk(acc_ff, 8'h83);
      ex(8'h43, 8'h30);
      chk(acc_ff, 8'hb3);
      timer_val = 8'h9c;
      ex(8'h42, 8'h00);
      chk(acc_ff, 8'h9c);
      ex(8'h23, 8'h6e);
      ex(8'h62, 8'h00);
      chk(timer_wdata_ff, 8'h6e);
      for (int p = 0; p < 4; p++) begin
         ex(8'h23, 8'hb8 + 8'(p));
         ex(8'h3c | 8'(p), 8'h00);
         chk(acc_ff, 8'hb8 + 8'(p));
      end
      for (int p = 0; p < 4; p++) begin
         ex(8'h0c | 8'(p), 8'h00);
         chk(acc_ff, 8'h08 + 8'(p));
         chk({6'h00, selected_port_ff}, 8'(p));
      end
      ex(8'hb8, 8'h3e);
      ex(8'h23, 8'hc3);
      ex(8'h90, 8'h00);
      chk(acc_ff, 8'hc3);
      ex(8'h23, 8'h00);
      ex(8'h80, 8'h00);
      chk(acc_ff, 8'hc3);
      ex(8'hf8, 8'h00);
      chk(acc_ff, 8'h3e);
      ex(8'h23, 8'h34);
      ex(8'ha3, 8'h00);
      chk(acc_ff, 8'h61);
      chk(rom_addr_ff[7:0], 8'h34);
      chk({4'h0, rom_addr_ff[11:8]}, 8'h05);
      ex(8'h23, 8'h12);
      ex(8'he3, 8'h00);
      chk(acc_ff, 8'h47);
      chk({5'h00, rom_addr_ff[10:8]}, 8'h03);
      ex(8'hc6, 8'h9e);
      chk({7'h00, saw}, 8'h00);
      ex(8'h23, 8'h00);
      ex(8'hc6, 8'h9e);
      chk({7'h00, saw}, 8'h01);
      chk(jaddr, 8'h9e);
      ex(8'h23, 8'h5c);
      ex(8'h00, 8'h00);
      chk(acc_ff, 8'h5c);
      // Enable low freezes everything, so the move is never taken
      ce = 1'b0;
      ex(8'h23, 8'hff);
      chk(acc_ff, 8'h5c);
      ce = 1'b1;
      ex(8'h88, 8'h5a);
      ex(8'h88, 8'h81);
      chk(bus_out_ff, 8'hdb);
      chk({7'h00, bus_oe_ff}, 8'h01);
      stop_test();
   end
endmodule : tb_mov_or_exec
